/* File: rtl/sdrb_pkg.sv */
`default_nettype none
package sdrb_pkg;
	// ----------------------------------------
	// Serial frame layout
	// ----------------------------------------
	localparam int unsigned DATA_W     = 18;  // Data bits per frame
	localparam int unsigned ADDR_W     = 4;   // Address bits per frame
	localparam int unsigned FRAME_BITS = 22;  // Data then address
	localparam int unsigned CNT_W      = 5;   // Bit counter width
	localparam logic [4:0]  CNT_FULL   = 5'h16; // 22 bits: a complete frame
	localparam logic [4:0]  CNT_SAT    = 5'h1F; // Counter stops here
	localparam int unsigned ADDR_LSB   = 0;   // Address field in frame
	localparam int unsigned DATA_LSB   = 4;   // Data field in frame

	// ----------------------------------------
	// Register address codes
	// ----------------------------------------
	localparam logic [3:0] ADDR_RF1_FB  = 4'h3;
	localparam logic [3:0] ADDR_RF2_FB  = 4'h4;
	localparam logic [3:0] ADDR_IF_FB   = 4'h5;
	localparam logic [3:0] ADDR_RF1_REF = 4'h6;
	localparam logic [3:0] ADDR_RF2_REF = 4'h7;
	localparam logic [3:0] ADDR_IF_REF  = 4'h8;
	localparam logic [3:0] ADDR_RSV_LO  = 4'h9;  // 9..15 reserved

	// ----------------------------------------
	// Field widths and reset values
	// ----------------------------------------
	localparam int unsigned RF1_FB_W = 18;  // Bits 17:0
	localparam int unsigned RF2_FB_W = 17;  // Bits 16:0
	localparam int unsigned IF_FB_W  = 16;  // Bits 15:0
	localparam int unsigned REF_W    = 13;  // Bits 12:0
	localparam logic [17:0] RF1_FB_RST = 18'h00000;
	localparam logic [16:0] RF2_FB_RST = 17'h00000;
	localparam logic [15:0] IF_FB_RST  = 16'h0000;
	localparam logic [12:0] REF_RST    = 13'h0000;

	// ----------------------------------------
	// Value limits
	// ----------------------------------------
	localparam logic [17:0] RF1_FB_MIN = 18'h003E0; // 992
	localparam logic [16:0] RF2_FB_MIN = 17'h000F0; // 240
	localparam logic [15:0] IF_FB_MIN  = 16'h0038;  // 56
	localparam logic [12:0] REF_MAX    = 13'h1FFD;  // 8189
	localparam logic [12:0] REF_MIN_G0 = 13'h0007;  // Gain code 00
	localparam logic [12:0] REF_MIN_G1 = 13'h0008;  // Gain code 01
	localparam logic [12:0] REF_MIN_G2 = 13'h000A;  // Gain code 10
	localparam logic [12:0] REF_MIN_G3 = 13'h000E;  // Gain code 11

	// ----------------------------------------
	// Frame tracker states (one-hot)
	// ----------------------------------------
	typedef enum logic [1:0] {
		FRM_IDLE = 2'b01,
		FRM_BUSY = 2'b10
	} sdrb_frame_type;
endpackage
`default_nettype wire

/* File: rtl/sdrb_top.sv */
`default_nettype none
module sdrb_top (
	// System clock and reset
	input  wire logic                          clock_i,
	input  wire logic                          sys_rst_i,
	// Three-wire serial port
	input  wire logic                          serial_clock_i,
	input  wire logic                          serial_data_in_i,
	input  wire logic                          serial_frame_enable_n_i,
	// Gain codes from the separate gain register
	input  wire logic [1:0]                    first_rf_gain_code_i,
	input  wire logic [1:0]                    second_rf_gain_code_i,
	input  wire logic [1:0]                    if_gain_code_i,
	// Divider values
	output logic      [sdrb_pkg::RF1_FB_W-1:0] first_rf_feedback_count_o,
	output logic      [sdrb_pkg::RF2_FB_W-1:0] second_rf_feedback_count_o,
	output logic      [sdrb_pkg::IF_FB_W-1:0]  if_feedback_count_o,
	output logic      [sdrb_pkg::REF_W-1:0]    first_rf_reference_count_o,
	output logic      [sdrb_pkg::REF_W-1:0]    second_rf_reference_count_o,
	output logic      [sdrb_pkg::REF_W-1:0]    if_reference_count_o,
	// Status
	output logic                               update_o,
	output logic      [sdrb_pkg::ADDR_W-1:0]   update_addr_o,
	output logic                               frame_error_o,
	output logic      [2:0]                    feedback_range_error_o,
	output logic      [2:0]                    reference_range_error_o
);
	import sdrb_pkg::*;

	// ----------------------------------------
	// Serial clock domain
	// ----------------------------------------
	logic [FRAME_BITS-1:0] shift_word;       // Bits as shifted in, MSB first
	logic [FRAME_BITS-1:0] next_shift_word;
	logic [CNT_W-1:0]      bit_count;        // Cleared by the idle frame enable
	logic [CNT_W-1:0]      next_bit_count;
	logic [CNT_W-1:0]      held_count;       // Count of the last frame, kept after it
	logic [CNT_W-1:0]      next_held_count;
	logic                  frame_idle;       // Enable inactive

	assign frame_idle = serial_frame_enable_n_i;

	// Bit count for the next serial edge
	always_comb begin
		if (bit_count == CNT_SAT) begin
			// Overlong frame: stop counting so it never looks complete
			next_bit_count = bit_count;
		end else begin
			next_bit_count = bit_count + 5'h01;
		end
	end

	// Shift word and count copy move only on edges inside a frame
	always_comb begin
		next_shift_word = shift_word;
		next_held_count = held_count;
		if (!frame_idle) begin
			next_shift_word = {shift_word[FRAME_BITS-2:0], serial_data_in_i};
			next_held_count = next_bit_count;
		end
	end

	// Bit counter, ended by the frame's own enable since the clock may stop
	always_ff @(posedge serial_clock_i or posedge frame_idle) begin
		if (frame_idle) begin
			bit_count <= 5'h00;
		end else begin
			bit_count <= next_bit_count;
		end
	end

	// Data and count copies survive the end of frame for the system side
	always_ff @(posedge serial_clock_i) begin
		shift_word <= next_shift_word;
		held_count <= next_held_count;
	end

	// ----------------------------------------
	// Enable synchroniser into system domain
	// ----------------------------------------
	logic       en_n_s1;      // First stage, read only by the second
	logic       en_n_s2;
	logic       en_n_s3;
	logic       en_n_level;   // Filtered enable level
	logic       next_en_n_level;

	// Three stages cost latency on the close, but the tracker never
	// sees a half-settled enable level
	// A change counts once stages two and three agree
	always_comb begin
		next_en_n_level = en_n_level;
		if (en_n_s2 == en_n_s3) begin
			next_en_n_level = en_n_s3;
		end
	end

	// Synchroniser stages
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			en_n_s1    <= 1'b1;
			en_n_s2    <= 1'b1;
			en_n_s3    <= 1'b1;
			en_n_level <= 1'b1;
		end else begin
			en_n_s1    <= serial_frame_enable_n_i;
			en_n_s2    <= en_n_s1;
			en_n_s3    <= en_n_s2;
			en_n_level <= next_en_n_level;
		end
	end

	// ----------------------------------------
	// Frame tracker
	// ----------------------------------------
	sdrb_frame_type frame_state;
	sdrb_frame_type next_frame_state;
	logic           frame_end;   // One cycle when a frame has closed

	// A frame shorter than two system clocks may be missed; one shorter than one clock is never seen
	// Open on enable active, close on enable inactive
	always_comb begin
		next_frame_state = frame_state;
		frame_end        = 1'b0;
		unique case (frame_state)
			FRM_IDLE: begin
				if (!en_n_level) begin
					next_frame_state = FRM_BUSY;
				end
			end
			FRM_BUSY: begin
				if (en_n_level) begin
					next_frame_state = FRM_IDLE;
					frame_end        = 1'b1;
				end
			end
			default: begin
				next_frame_state = FRM_IDLE;
			end
		endcase
	end

	// Tracker state register
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			frame_state <= FRM_IDLE;
		end else begin
			frame_state <= next_frame_state;
		end
	end

	// ----------------------------------------
	// Frame decode
	// ----------------------------------------
	logic [ADDR_W-1:0] frame_addr;
	logic [DATA_W-1:0] frame_data;
	logic              frame_ok;

	// Serial words are static while the enable is idle, so reading them
	// here is safe; the limit is that the host must not reopen a frame
	// within the synchroniser delay.
	assign frame_addr = shift_word[ADDR_LSB +: ADDR_W];
	assign frame_data = shift_word[DATA_LSB +: DATA_W];
	assign frame_ok   = frame_end && (held_count == CNT_FULL);

	// ----------------------------------------
	// Divider registers
	// ----------------------------------------
	logic [RF1_FB_W-1:0] next_rf1_fb;
	logic [RF2_FB_W-1:0] next_rf2_fb;
	logic [IF_FB_W-1:0]  next_if_fb;
	logic [REF_W-1:0]    next_rf1_ref;
	logic [REF_W-1:0]    next_rf2_ref;
	logic [REF_W-1:0]    next_if_ref;
	logic                next_update;
	logic [ADDR_W-1:0]   next_update_addr;
	logic                next_frame_error;

	// Addressed write; upper bits that must be zero are not stored
	always_comb begin
		next_rf1_fb      = first_rf_feedback_count_o;
		next_rf2_fb      = second_rf_feedback_count_o;
		next_if_fb       = if_feedback_count_o;
		next_rf1_ref     = first_rf_reference_count_o;
		next_rf2_ref     = second_rf_reference_count_o;
		next_if_ref      = if_reference_count_o;
		next_update      = 1'b0;
		next_update_addr = update_addr_o;
		next_frame_error = frame_end && !frame_ok;
		if (frame_ok) begin
			next_update      = (frame_addr >= ADDR_RF1_FB) && (frame_addr < ADDR_RSV_LO);
			next_update_addr = frame_addr;
			unique case (frame_addr)
				ADDR_RF1_FB: begin
					next_rf1_fb = frame_data[RF1_FB_W-1:0];
				end
				ADDR_RF2_FB: begin
					next_rf2_fb = frame_data[RF2_FB_W-1:0];
				end
				ADDR_IF_FB: begin
					next_if_fb = frame_data[IF_FB_W-1:0];
				end
				ADDR_RF1_REF: begin
					next_rf1_ref = frame_data[REF_W-1:0];
				end
				ADDR_RF2_REF: begin
					next_rf2_ref = frame_data[REF_W-1:0];
				end
				ADDR_IF_REF: begin
					next_if_ref = frame_data[REF_W-1:0];
				end
				default: begin
					// Codes 0-2 live elsewhere; 9-15 are reserved and dropped
					next_update_addr = update_addr_o;
				end
			endcase
		end
	end

	// Dividers start at zero; the host must load them before use
	// Register bank
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			first_rf_feedback_count_o   <= RF1_FB_RST;
			second_rf_feedback_count_o  <= RF2_FB_RST;
			if_feedback_count_o         <= IF_FB_RST;
			first_rf_reference_count_o  <= REF_RST;
			second_rf_reference_count_o <= REF_RST;
			if_reference_count_o        <= REF_RST;
			update_o                    <= 1'b0;
			update_addr_o               <= 4'h0;
			frame_error_o               <= 1'b0;
		end else begin
			first_rf_feedback_count_o   <= next_rf1_fb;
			second_rf_feedback_count_o  <= next_rf2_fb;
			if_feedback_count_o         <= next_if_fb;
			first_rf_reference_count_o  <= next_rf1_ref;
			second_rf_reference_count_o <= next_rf2_ref;
			if_reference_count_o        <= next_if_ref;
			update_o                    <= next_update;
			update_addr_o               <= next_update_addr;
			frame_error_o               <= next_frame_error;
		end
	end

	// ----------------------------------------
	// Range monitors
	// ----------------------------------------
	// Least reference value for a gain code
	function automatic logic [REF_W-1:0] ref_floor(input logic [1:0] gain);
		logic [REF_W-1:0] floor_val;
		floor_val = REF_MIN_G0;
		unique case (gain)
			2'b00: floor_val = REF_MIN_G0;
			2'b01: floor_val = REF_MIN_G1;
			2'b10: floor_val = REF_MIN_G2;
			2'b11: floor_val = REF_MIN_G3;
		endcase
		return floor_val;
	endfunction

	// Flag state, one bit per synthesizer
	logic [2:0] next_fb_err;
	logic [2:0] next_ref_err;

	// Flags are advisory only: the host owns the values, the bank never clips
	always_comb begin
		next_fb_err[0]  = first_rf_feedback_count_o < RF1_FB_MIN;
		next_fb_err[1]  = second_rf_feedback_count_o < RF2_FB_MIN;
		next_fb_err[2]  = if_feedback_count_o < IF_FB_MIN;
		next_ref_err[0] = (first_rf_reference_count_o > REF_MAX)
			|| (first_rf_reference_count_o < ref_floor(first_rf_gain_code_i));
		next_ref_err[1] = (second_rf_reference_count_o > REF_MAX)
			|| (second_rf_reference_count_o < ref_floor(second_rf_gain_code_i));
		next_ref_err[2] = (if_reference_count_o > REF_MAX)
			|| (if_reference_count_o < ref_floor(if_gain_code_i));
	end

	// Flag registers
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			feedback_range_error_o  <= 3'h0;
			reference_range_error_o <= 3'h0;
		end else begin
			feedback_range_error_o  <= next_fb_err;
			reference_range_error_o <= next_ref_err;
		end
	end
endmodule // sdrb_top
`default_nettype wire

/* File: tb/sdrb_host.sv */
`default_nettype none
// ---------------------------
// Host on the serial link
// ---------------------------
module sdrb_host (
	// Link pins
	output logic sclk_o,
	output logic serial_data_in_o,
	output logic sen_n_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle: clock still, frame closed
	initial begin
		sclk_o = 1'b0;
		serial_data_in_o = 1'b0;
		sen_n_o = 1'b1;
	end
	// n bits MSB first; slow waits long before clocking
	task automatic send(input logic [31:0] w, input int n, input bit slow);
		int i;
		sen_n_o = 1'b0;
		#(slow ? 400.0 : 1.3);
		for (i = n - 1; i >= 0; i--) begin
			serial_data_in_o = w[i];
			#80 sclk_o = 1'b1;
			#80 sclk_o = 1'b0;
		end
		#40 sen_n_o = 1'b1;
		// No pull on data: show the inverse once released
		serial_data_in_o = ~serial_data_in_o;
	endtask
endmodule // sdrb_host
`default_nettype wire

/* File: tb/sdrb_props.sv */
`default_nettype none
// ---------------------------
// Port checker, divider bank
// ---------------------------
module sdrb_props (
	// Clock, reset, frame enable
	input wire logic                            clock_i,
	input wire logic                            sys_rst_i,
	input wire logic                            serial_frame_enable_n_i,
	// Watched dividers
	input wire logic [sdrb_pkg::RF1_FB_W-1:0]   first_rf_feedback_count_o,
	input wire logic [sdrb_pkg::REF_W-1:0]      second_rf_reference_count_o,
	input wire logic [sdrb_pkg::REF_W-1:0]      if_reference_count_o,
	// Status
	input wire logic                            update_o,
	input wire logic [sdrb_pkg::ADDR_W-1:0]     update_addr_o,
	input wire logic                            frame_error_o,
	input wire logic [2:0]                      feedback_range_error_o,
	input wire logic [2:0]                      reference_range_error_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import sdrb_pkg::*;
	// One domain, so one default clock and reset
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);
	// A divider moves only on a write to its own code
	a_rf1_fb_moves: assert property ($changed(first_rf_feedback_count_o)
		|-> update_o && update_addr_o == ADDR_RF1_FB) else $error("rf1 feedback moved");
	a_rf2_ref_moves: assert property ($changed(second_rf_reference_count_o)
		|-> update_o && update_addr_o == ADDR_RF2_REF) else $error("rf2 reference moved");
	// Status pulses last one cycle and never coincide
	a_upd_one_cycle: assert property (update_o |=> !update_o)
		else $error("update longer than one cycle");
	a_err_lone_pulse: assert property (frame_error_o |-> !update_o ##1 !frame_error_o)
		else $error("frame error not a lone pulse");
	// Writes land only after the enable closed the frame
	a_upd_after_close: assert property (update_o |-> serial_frame_enable_n_i
		&& $past(serial_frame_enable_n_i, 3)) else $error("write before frame closed");
	a_upd_addr_range: assert property (update_o |-> update_addr_o inside {[4'h3:4'h8]})
		else $error("write to a reserved code");
	// Advisory flags follow the stored value one cycle later
	a_fb_low_flag: assert property (!sys_rst_i && first_rf_feedback_count_o < RF1_FB_MIN
		|=> feedback_range_error_o[0]) else $error("rf1 low flag missing");
	a_ref_high_flag: assert property (if_reference_count_o > REF_MAX
		|=> reference_range_error_o[2]) else $error("if high flag missing");
	c_write: cover property (update_o);
	c_frame_err: cover property (frame_error_o);
	c_ref_flag: cover property (reference_range_error_o[2]);
endmodule // sdrb_props

bind sdrb_top sdrb_props u_sdrb_props (
	.clock_i, .sys_rst_i, .serial_frame_enable_n_i, .first_rf_feedback_count_o,
	.second_rf_reference_count_o, .if_reference_count_o, .update_o, .update_addr_o,
	.frame_error_o, .feedback_range_error_o, .reference_range_error_o
);
`default_nettype wire

/* File: tb/tb_sdrb_top.sv */
`default_nettype none
// ---------------------------
// Bench for the divider bank
// ---------------------------
module tb_sdrb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sdrb_pkg::*;
	// Design pins
	logic        clock_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic [1:0]  g1 = 2'h0, g2 = 2'h0, gi = 2'h0;
	logic        sclk, sdat, sen_n, upd, err;
	logic [17:0] fb1, d;
	logic [16:0] fb2;
	logic [15:0] fbi;
	logic [12:0] rr1, rr2, rri;
	logic [3:0]  uaddr;
	logic [2:0]  fbe, rfe;
	// Model state; int zero matches the reset value
	int          m[3:8];
	int          wid[3:8] = '{18, 17, 16, 13, 13, 13};
	int          floor_tab[4] = '{7, 8, 10, 14};
	int          ntab[4] = '{991, 4095, 8192, 16383}; // RF1 feedback per gain step
	int          cmp_count = 0, miscompares = 0, a, g;
	logic [31:0] rng = 32'hE3B9CFAE;
	always #2.5 clock_i = ~clock_i;
	sdrb_top u_sdrb_top (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i),
		.serial_clock_i(sclk), .serial_data_in_i(sdat), .serial_frame_enable_n_i(sen_n),
		.first_rf_gain_code_i(g1), .second_rf_gain_code_i(g2), .if_gain_code_i(gi),
		.first_rf_feedback_count_o(fb1), .second_rf_feedback_count_o(fb2),
		.if_feedback_count_o(fbi), .first_rf_reference_count_o(rr1),
		.second_rf_reference_count_o(rr2), .if_reference_count_o(rri),
		.update_o(upd), .update_addr_o(uaddr), .frame_error_o(err),
		.feedback_range_error_o(fbe), .reference_range_error_o(rfe)
	);
	sdrb_host u_sdrb_host (.sclk_o(sclk), .serial_data_in_o(sdat), .sen_n_o(sen_n));
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	// Reference out of range for its gain code
	function automatic logic bad(input int v, input logic [1:0] gc);
		return v > 8189 || v < floor_tab[gc];
	endfunction
	// RF1 gain code picked from its feedback value
	function automatic logic [1:0] kp1(input int n);
		return (n < 4096) ? 2'h0 : (n < 8192) ? 2'h1 : (n < 16384) ? 2'h2 : 2'h3;
	endfunction
	task automatic cmp(input logic [17:0] got, input logic [17:0] exp, input string s);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
		end
	endtask
	task automatic check_all();
		cmp(18'(fb1), 18'(m[3]), "rf1 fb");
		cmp(18'(fb2), 18'(m[4]), "rf2 fb");
		cmp(18'(fbi), 18'(m[5]), "if fb");
		cmp(18'(rr1), 18'(m[6]), "rf1 ref");
		cmp(18'(rr2), 18'(m[7]), "rf2 ref");
		cmp(18'(rri), 18'(m[8]), "if ref");
		cmp(18'(fbe), 18'({m[5] < 56, m[4] < 240, m[3] < 992}), "fb flags");
		cmp(18'(rfe), 18'({bad(m[8], gi), bad(m[7], g2), bad(m[6], g1)}), "ref flags");
	endtask
	// One frame, then a fixed window that outlasts the answer
	task automatic frame(input logic [3:0] ad, input logic [17:0] dv, input int n, input bit sl);
		int up, er, k;
		bit wr;
		up = 0;
		er = 0;
		wr = (n == 22 && ad inside {[3:8]});
		if (wr && ad == 4'h3) begin
			@(posedge clock_i);
			g1 <= kp1(int'(dv));
		end
		u_sdrb_host.send({10'h0, dv, ad}, n, sl);
		for (k = 0; k < 12; k++) begin
			@(posedge clock_i);
			#1;
			up += int'(upd === 1'b1);
			er += int'(err === 1'b1);
		end
		if (wr)
			m[ad] = int'(dv) % (1 << wid[ad]);
		cmp(18'(up), 18'(wr), "updates");
		cmp(18'(er), 18'(n != 22), "errors");
		if (wr)
			cmp(18'(uaddr), 18'(ad), "address");
		check_all();
	endtask
	task automatic final_report();
		$display("Compared %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard
	initial begin
		#400000;
		miscompares++;
		final_report();
	end
	initial begin
		repeat (8) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		#1;
		check_all();
		// Every code but the reserved ones, random data; upper bits zero for codes 3-8
		for (a = 0; a < 9; a++) begin
			d = 18'(xs());
			if (a inside {[3:8]})
				d = 18'(int'(d) % (1 << wid[a]));
			frame(4'(a), d, 22, a[0]);
		end
		// Boundary values, each synthesizer on a different gain
		for (g = 0; g < 4; g++) begin
			@(posedge clock_i);
			g2 <= 2'(g + 1);
			gi <= 2'(g + 2);
			frame(4'h3, 18'(ntab[g] + g % 2), 22, 0);
			frame(4'h4, 18'(239 + g % 2), 22, 1);
			frame(4'h5, 18'(55 + g % 2), 22, 0);
			frame(4'h6, 18'(floor_tab[g] - g % 2), 22, 0);
			frame(4'h7, 18'(floor_tab[g]), 22, 0);
			frame(4'h8, 18'(8189 + g % 2), 22, 0);
		end
		// Short and long frames leave the bank alone
		frame(4'h3, 18'h3FFFF, 21, 0);
		frame(4'h4, 18'h00001, 23, 1);
		final_report();
	end
endmodule // tb_sdrb_top
`default_nettype wire
